// ---- sim/uart_rx_range_multiproc_filter_tb.sv ----
/*
 * Self-checking bench: master end sends frames to the device end over the link.
 * Assumes the device is reached over APB and answers on its own handshake.
 */
`timescale 1ns/1ps

module uart_rx_range_multiproc_filter_tb import uartmp_pkg::*;;
    logic pclk = 0;
    logic presetn = 0;
    logic psel = 0;
    logic penable = 0;
    logic pwrite = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic send = 0;
    logic send_addr = 0;
    logic [8:0] send_data = 9'h000;
    logic [2:0] char_size_sel = 3'h3;
    logic par_en = 0;
    logic par_odd = 0;
    logic double_speed_sel = 0;
    logic [11:0] baud_divisor = 12'h000;
    logic busy;
    logic [31:0] rd;
    logic [31:0] rng = 32'h0000_003A;
    logic err;
    logic last_fe = 0;
    logic filt_on = 0;
    logic [2:0] sizes [5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h7};
    int mismatches = 0;
    int total_checks = 0;
    int cycles = 0;

    uartmp_link_if link();
    uartmp_master uartmp_master_i (.pclk(pclk), .presetn(presetn), .link(link), .send(send),
        .send_data(send_data), .send_addr(send_addr), .char_size_sel(char_size_sel), .par_en(par_en),
        .par_odd(par_odd), .double_speed_sel(double_speed_sel), .baud_divisor(baud_divisor), .busy(busy));
    uartmp_device uartmp_device_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .link(link));
    uartmp_checker uartmp_checker_i (.pclk(pclk), .presetn(presetn), .m2d_line(link.m2d_line),
        .d2m_line(link.d2m_line), .psel(psel), .penable(penable), .paddr(paddr), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .busy(busy), .double_speed_sel(double_speed_sel),
        .baud_divisor(baud_divisor));

    ////////////////////////////////////////////////////////////////////////
    // Clock and a cycle ceiling so that a hang still ends in the report.
    initial begin
        forever #20 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 60000) begin
            mismatches++;
            finish_test();
        end
    end

    // Fixed-seed xorshift keeps every run identical.
    function automatic logic [31:0] rnd();
        rng = rng ^ (rng << 13);
        rng = rng ^ (rng >> 17);
        rng = rng ^ (rng << 5);
        return rng;
    endfunction

    task automatic finish_test();
        if (mismatches == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        total_checks++;
        if (s !== e) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask

    // One APB transfer; the request is held until pready is seen at an edge.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Both ends get the same frame format; the device readback proves one shared size field.
    task automatic cfg(input logic [2:0] c, input logic pe, odd, ds, f, input logic [11:0] bd);
        filt_on = f;
        apb(1, ADDR_BAUD, {20'h0_0000, bd});
        apb(1, ADDR_CSB, {24'h00_0000, odd, pe, 1'b1, c, 2'b11});
        apb(1, ADDR_CSA, {30'h0000_0000, ds, f});
        char_size_sel <= c;
        par_en <= pe;
        par_odd <= odd;
        double_speed_sel <= ds;
        baud_divisor <= bd;
        apb(0, ADDR_CSB, 32'h0000_0000);
        chk("ctrl_b", rd & 32'h0000_01FF, {24'h00_0000, odd, pe, 1'b1, c, 2'b11});
    endtask

    // Send holds until the master takes it, which it does at the next idle edge without waiting for a sample tick.
    task automatic tx_frame(input logic t, input logic [8:0] d);
        @(posedge pclk);
        send <= 1;
        send_data <= d;
        send_addr <= t;
        do @(posedge pclk); while (busy !== 1'b1);
        send <= 0;
        while (busy !== 1'b0) @(posedge pclk);
        repeat (4) @(posedge pclk);
    endtask

    // Short sizes mark the type in the first stop, so a passed data frame is a frame error.
    task automatic rx_check(input logic st, t, input logic [8:0] d);
        logic [3:0] nb;
        logic [7:0] mask;
        nb = (char_size_sel == 3'h7) ? 4'h9 : {2'b00, char_size_sel[1:0]} + 4'h5;
        mask = (nb > 4'h8) ? 8'hFF : 8'hFF >> (4'h8 - nb);
        if (st) last_fe = (char_size_sel != 3'h7) && !t;
        apb(0, ADDR_CSA, 32'h0000_0000);
        chk("status_a", rd & 32'h0000_009F, {24'h00_0000, st, 2'b00, last_fe, 2'b00, double_speed_sel, filt_on});
        if (st) begin
            apb(0, ADDR_DATA, 32'h0000_0000);
            chk("rx_data", rd, {24'h00_0000, d[7:0] & mask});
            if (char_size_sel == 3'h7) begin
                apb(0, ADDR_CSB, 32'h0000_0000);
                chk("ninth", {31'h0000_0000, rd[9]}, {31'h0000_0000, t});
            end
            apb(0, ADDR_CSA, 32'h0000_0000);
            chk("rx_flag", {31'h0000_0000, rd[7]}, 32'h0000_0000);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Main sequence: reset values, fixed corner frames, random frames, overrun, then transmitter flags.
    initial begin
        logic [31:0] r;
        int n;
        repeat (8) @(posedge pclk);
        presetn <= 1;
        apb(0, ADDR_CSA, 32'h0000_0000);
        chk("csa_reset", rd, 32'h0000_0001 << CSA_TXE);
        apb(0, ADDR_CSB, 32'h0000_0000);
        chk("csb_reset", rd, {22'h00_0000, CSB_RESET});
        apb(0, ADDR_BAUD, 32'h0000_0000);
        chk("baud_reset", rd, {20'h0_0000, BAUD_RESET});
        apb(0, 12'h010, 32'h0000_0000);
        chk("unmapped", {err, rd[30:0]}, 32'h8000_0000);
        cfg(3'h7, 0, 0, 0, 1, 12'h000);
        tx_frame(1, 9'h1A5);
        rx_check(1, 1, 9'h1A5);
        tx_frame(0, 9'h03C);
        rx_check(0, 0, 9'h03C);
        tx_frame(1, 9'h155);
        tx_frame(0, 9'h0AA);
        rx_check(1, 1, 9'h155);
        cfg(3'h7, 0, 0, 0, 0, 12'h000);
        tx_frame(0, 9'h033);
        rx_check(1, 0, 9'h033);
        cfg(3'h0, 1, 1, 1, 1, 12'h000);
        tx_frame(1, 9'h015);
        rx_check(1, 1, 9'h015);
        tx_frame(0, 9'h00A);
        rx_check(0, 0, 9'h00A);
        for (int i = 0; i < 14; i++) begin
            r = rnd();
            cfg(sizes[r[2:0] % 3'h5], r[3], r[4], r[5], r[6], {10'h000, r[8:7] % 2'h3});
            tx_frame(r[9], {r[9], r[17:10]});
            rx_check(!r[6] || r[9], r[9], {r[9], r[17:10]});
        end
        // Two unread address frames: the second overwrites the buffer and flags overrun.
        cfg(3'h3, 0, 0, 0, 0, 12'h000);
        tx_frame(1, 9'h011);
        tx_frame(1, 9'h022);
        apb(0, ADDR_CSA, 32'h0000_0000);
        chk("overrun", rd & 32'h0000_0098, 32'h0000_0088);
        apb(0, ADDR_DATA, 32'h0000_0000);
        chk("rx_last", rd, 32'h0000_0022);
        cfg(3'h3, 0, 0, 0, 1, 12'h000);
        apb(1, ADDR_DATA, 32'h0000_005A);
        // Start bit and data bit 0 of 0x5A are both low: two bit times of 16 samples each.
        while (link.d2m_line !== 1'b0) @(posedge pclk);
        n = 0;
        while (link.d2m_line === 1'b0) begin
            @(posedge pclk);
            n++;
        end
        chk("tx_low_len", n, 32'h0000_0020);
        n = 0;
        do begin
            apb(0, ADDR_CSA, 32'h0000_0000);
            n++;
        end while (rd[6] !== 1'b1 && n < 400);
        chk("tx_done", {31'h0000_0000, rd[6]}, 32'h0000_0001);
        apb(1, ADDR_CSA, 32'h0000_0001);
        apb(0, ADDR_CSA, 32'h0000_0000);
        chk("txc_kept", rd & 32'h0000_0041, 32'h0000_0041);
        apb(1, ADDR_CSA, 32'h0000_0041);
        apb(0, ADDR_CSA, 32'h0000_0000);
        chk("txc_clear", rd & 32'h0000_0041, 32'h0000_0001);
        finish_test();
    end
endmodule

// ---- sim/uartmp_checker.sv ----
/*
 * Concurrent checks on the master-to-device link and the device APB port.
 * Assumes the bench hands it the interface lines and both ends' port signals.
 */
`timescale 1ns/1ps

module uartmp_checker (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic m2d_line,
    input wire logic d2m_line,
    input wire logic psel,
    input wire logic penable,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic busy,
    input wire logic double_speed_sel,
    input wire logic [11:0] baud_divisor
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    ////////////////////////////////////////////////////////////////////////
    // At the fastest divisor one sample is one clock, so a start bit is a whole sample count long.
    a_start_normal_len: assert property ($rose(busy) && baud_divisor == 12'h000 && !double_speed_sel |->
        !m2d_line [*8] ##1 !m2d_line [*8]) else $error("start bit shorter than sixteen samples");
    a_start_double_len: assert property ($rose(busy) && baud_divisor == 12'h000 && double_speed_sel |->
        !m2d_line [*8]) else $error("start bit shorter than eight samples");
    a_line_idle_free: assert property (!busy |-> m2d_line)
        else $error("link driven low while master idle");
    a_stop_high_end: assert property ($fell(busy) |-> $past(m2d_line) && m2d_line)
        else $error("frame did not end on a high stop bit");
    a_lines_after_rst: assert property ($rose(presetn) |-> m2d_line && d2m_line)
        else $error("link lines not idle after reset");

    ////////////////////////////////////////////////////////////////////////
    // The register port answers in exactly one access cycle.
    a_pready_one_wait: assert property (psel && !penable |=> pready)
        else $error("no answer in the access cycle");
    a_pready_cause: assert property (pready |-> psel && penable && $past(psel && !penable))
        else $error("answer without a preceding setup");
    a_prdata_quiet: assert property (!pready |-> prdata == 32'h0000_0000)
        else $error("read data not zero outside an answer");
    a_unmapped_err: assert property (pready && paddr[11:4] != 8'h00 |-> pslverr)
        else $error("unmapped access not refused");
    a_mapped_ok: assert property (pready && paddr[11:4] == 8'h00 && paddr[1:0] == 2'b00 |-> !pslverr)
        else $error("mapped access refused");

    c_frame_done: cover property ($fell(busy));
    c_refused: cover property (pready && pslverr);
    c_dev_sends: cover property ($fell(d2m_line));
endmodule

// ---- verilog/uartmp_device.sv ----
/*
 * Device end of the multi-drop link: an APB-mapped transmitter and an
 * oversampling receiver with address filtering.
 * Assumes an APB master on pclk and a link partner keeping its bit rate.
 */
`timescale 1ns/1ps

module uartmp_device
    import uartmp_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    uartmp_link_if.dev link
);

    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS, RX_STOP} uartmp_rx_state_t;

    // Register state.
    logic addr_filter_mode;
    logic double_speed_sel;
    logic [9:0] csb;
    logic [11:0] baud_divisor;
    logic rx_complete_flag;
    logic tx_complete_flag;
    logic [7:0] rx_data;
    logic rx_ninth_bit;
    logic perr;
    logic ferr;
    logic ovr;

    // Bus and decoded controls.
    logic wr_done;
    logic rd_done;
    logic hit;
    logic [31:0] rd_val;
    logic [3:0] nb;
    logic [3:0] s_last;
    logic [3:0] v_first;

    // Receiver.
    logic rx_meta;
    logic rx_sync;
    logic [11:0] baud_cnt;
    logic tick;
    uartmp_rx_state_t rx_state;
    logic [3:0] rx_samp;
    logic [1:0] votes;
    logic dec;
    logic vote;
    logic [3:0] rx_cnt;
    logic [9:0] rx_sh;
    logic [9:0] rx_val;
    logic rx_done;
    logic rx_type;
    logic rx_stop;

    // Transmitter.
    logic tx_pending;
    logic [8:0] tx_hold;
    logic tx_busy;
    logic [FRAME_MAX-1:0] tx_sh;
    logic [3:0] tx_left;
    logic [3:0] tx_samp;
    logic tx_line;

    ////////////////////////////////////////////////////////////////////
    // Decoded settings; one size code serves both directions.
    assign nb = data_bits(csb[CSB_CSZ +: 3]);
    assign s_last = last_sample(double_speed_sel);
    assign v_first = double_speed_sel ? VOTE_FIRST_DOUBLE : VOTE_FIRST_NORMAL;
    assign wr_done = psel && penable && pready && pwrite;
    assign rd_done = psel && penable && pready && !pwrite;
    assign hit = (paddr == ADDR_DATA) || (paddr == ADDR_CSA) || (paddr == ADDR_CSB) || (paddr == ADDR_BAUD);

    // Read mux.
    always_comb begin
        rd_val = 32'h0000_0000;
        case (paddr)
            ADDR_DATA: rd_val = {24'h00_0000, rx_data};
            ADDR_CSA: rd_val = {24'h00_0000, rx_complete_flag, tx_complete_flag, !tx_pending, ferr, ovr, perr,
                                double_speed_sel, addr_filter_mode};
            ADDR_CSB: rd_val = {22'h00_0000, rx_ninth_bit, csb[8:0]};
            ADDR_BAUD: rd_val = {20'h0_0000, baud_divisor};
            default: rd_val = 32'h0000_0000;
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // APB slave: pready rises one cycle after setup, so every access has no wait.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !hit;
            prdata <= (psel && !penable && !pwrite) ? rd_val : 32'h0000_0000;
        end
    end

    // Control registers. Writing one to the tx flag position clears it, hence no read-modify-write.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            addr_filter_mode <= 1'b0;
            double_speed_sel <= 1'b0;
            csb <= CSB_RESET;
            baud_divisor <= BAUD_RESET;
        end else if (wr_done) begin
            if (paddr == ADDR_CSA) begin
                addr_filter_mode <= pwdata[CSA_AFM];
                double_speed_sel <= pwdata[CSA_DSS];
            end
            if (paddr == ADDR_CSB) begin
                csb <= {1'b0, pwdata[8:0]};
            end
            if (paddr == ADDR_BAUD) begin
                baud_divisor <= pwdata[11:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Line synchroniser; only the second stage is looked at.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_meta <= 1'b1;
            rx_sync <= 1'b1;
        end else begin
            rx_meta <= link.m2d_line;
            rx_sync <= rx_meta;
        end
    end

    // Sample tick shared by both directions.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            baud_cnt <= 12'h000;
        end else begin
            baud_cnt <= tick ? baud_divisor : baud_cnt - 12'h001;
        end
    end
    assign tick = (baud_cnt == 12'h000);

    // Two-of-three vote on the stored pair and the current sample.
    assign vote = (votes[0] & votes[1]) | (votes[0] & rx_sync) | (votes[1] & rx_sync);
    assign rx_val = rx_sh >> (4'hA - nb - {3'b000, csb[CSB_PAR_EN]});

    ////////////////////////////////////////////////////////////////////
    // Receive sequencer. The frame ends right after the stop vote so an early start is caught.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_state <= RX_IDLE;
            rx_samp <= 4'h0;
            votes <= 2'b00;
            dec <= 1'b1;
            rx_cnt <= 4'h0;
            rx_sh <= 10'h000;
            rx_done <= 1'b0;
            rx_stop <= 1'b1;
        end else begin
            rx_done <= 1'b0;
            if (!csb[CSB_RXEN]) begin
                rx_state <= RX_IDLE;
            end else if (tick) begin
                rx_samp <= (rx_samp == s_last) ? 4'h1 : rx_samp + 4'h1;
                if (rx_samp == v_first) begin
                    votes[0] <= rx_sync;
                end
                if (rx_samp == v_first + 4'h1) begin
                    votes[1] <= rx_sync;
                end
                if (rx_samp == v_first + 4'h2) begin
                    dec <= vote;
                end
                case (rx_state)
                    RX_IDLE: begin
                        if (!rx_sync) begin
                            rx_state <= RX_START;
                            rx_samp <= 4'h2;
                        end
                    end
                    RX_START: begin
                        if (rx_samp == v_first + 4'h2 && vote) begin
                            rx_state <= RX_IDLE;
                        end else if (rx_samp == s_last) begin
                            rx_state <= RX_BITS;
                            rx_cnt <= 4'h0;
                        end
                    end
                    RX_BITS: begin
                        if (rx_samp == s_last) begin
                            rx_sh <= {dec, rx_sh[9:1]};
                            rx_cnt <= rx_cnt + 4'h1;
                            if (rx_cnt + 4'h1 == nb + {3'b000, csb[CSB_PAR_EN]}) begin
                                rx_state <= RX_STOP;
                            end
                        end
                    end
                    RX_STOP: begin
                        if (rx_samp == v_first + 4'h2) begin
                            rx_stop <= vote;
                            rx_done <= 1'b1;
                            rx_state <= RX_IDLE;
                        end
                    end
                    default: rx_state <= RX_IDLE;
                endcase
            end
        end
    end

    // Frame type: ninth bit for nine-bit frames, else the first stop bit; one means address.
    assign rx_type = (nb == 4'h9) ? rx_val[8] : rx_stop;

    // Receive buffer and flags; a new frame wins over a clearing read in the same cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_complete_flag <= 1'b0;
            rx_data <= 8'h00;
            rx_ninth_bit <= 1'b0;
            perr <= 1'b0;
            ferr <= 1'b0;
            ovr <= 1'b0;
        end else if (!csb[CSB_RXEN]) begin
            rx_complete_flag <= 1'b0;
        end else if (rx_done && (rx_type || !addr_filter_mode)) begin
            rx_complete_flag <= 1'b1;
            rx_data <= rx_val[7:0] & ~(8'hFF << nb);
            rx_ninth_bit <= rx_val[8] && (nb == 4'h9);
            ferr <= !rx_stop;
            perr <= csb[CSB_PAR_EN] && (^(rx_val[8:0] & ~(9'h1FF << nb)) ^ rx_val[nb] ^ csb[CSB_PAR_ODD]);
            ovr <= rx_complete_flag && !(rd_done && paddr == ADDR_DATA);
        end else if (rd_done && paddr == ADDR_DATA) begin
            rx_complete_flag <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Transmit holding register, written over the bus.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_pending <= 1'b0;
            tx_hold <= 9'h000;
        end else if (wr_done && paddr == ADDR_DATA && !tx_pending) begin
            tx_pending <= 1'b1;
            tx_hold <= {csb[CSB_TXB8], pwdata[7:0]};
        end else if (tx_pending && !tx_busy && tick && csb[CSB_TXEN]) begin
            tx_pending <= 1'b0;
        end
    end

    // Transmit shifter; it never looks at the filter bit.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_busy <= 1'b0;
            tx_sh <= '1;
            tx_left <= 4'h0;
            tx_samp <= 4'h0;
            tx_line <= 1'b1;
        end else if (tx_pending && !tx_busy && tick && csb[CSB_TXEN]) begin
            tx_busy <= 1'b1;
            tx_sh <= build_frame(tx_hold, nb, csb[CSB_PAR_EN], csb[CSB_PAR_ODD]);
            tx_left <= frame_len(nb, csb[CSB_PAR_EN], csb[CSB_TWO_STOP]);
            tx_samp <= 4'h1;
            tx_line <= 1'b0;
        end else if (tx_busy && tick) begin
            tx_samp <= (tx_samp == s_last) ? 4'h1 : tx_samp + 4'h1;
            if (tx_samp == s_last) begin
                tx_sh <= {1'b1, tx_sh[FRAME_MAX-1:1]};
                tx_line <= tx_sh[1];
                tx_left <= tx_left - 4'h1;
                if (tx_left == 4'h1) begin
                    tx_busy <= 1'b0;
                    tx_line <= 1'b1;
                end
            end
        end
    end
    assign link.d2m_line = tx_line;

    // Transmit complete: set at the end of the last stop bit with nothing queued; the set wins.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_complete_flag <= 1'b0;
        end else if (tx_busy && tick && tx_samp == s_last && tx_left == 4'h1 && !tx_pending) begin
            tx_complete_flag <= 1'b1;
        end else if (wr_done && paddr == ADDR_CSA && pwdata[CSA_TXC]) begin
            tx_complete_flag <= 1'b0;
        end
    end

endmodule

// ---- verilog/uartmp_link_if.sv ----
/*
 * Serial link between the master end and one device end.
 * Each direction is a separate line; both idle high.
 */
`timescale 1ns/1ps

interface uartmp_link_if;
    logic m2d_line;
    logic d2m_line;

    modport dev (input m2d_line, output d2m_line);
    modport mst (output m2d_line, input d2m_line);
endinterface

// ---- verilog/uartmp_master.sv ----
/*
 * Master end of the multi-drop link: sends address and data frames.
 * Assumes a user that pulses send only while busy is low.
 */
`timescale 1ns/1ps

module uartmp_master
    import uartmp_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    uartmp_link_if.mst link,
    input wire logic send,
    input wire logic [8:0] send_data,
    input wire logic send_addr,
    input wire logic [2:0] char_size_sel,
    input wire logic par_en,
    input wire logic par_odd,
    input wire logic double_speed_sel,
    input wire logic [11:0] baud_divisor,
    output logic busy
);

    logic [11:0] baud_cnt;
    logic tick;
    logic [FRAME_MAX-1:0] shreg;
    logic [3:0] left;
    logic [3:0] samp;
    logic line;
    logic [3:0] nb;
    logic [FRAME_MAX-1:0] frame;

    ////////////////////////////////////////////////////////////////////
    // Frame assembly: the frame type rides in the ninth bit or the first stop bit.
    always_comb begin
        nb = data_bits(char_size_sel);
        frame = build_frame({send_addr, send_data[7:0]}, nb, par_en, par_odd);
        if (char_size_sel != CSZ_NINE) begin
            frame = build_frame(send_data, nb, par_en, par_odd);
            frame[nb + {3'b000, par_en} + 4'h1] = send_addr;
        end
    end

    assign link.m2d_line = line;

    // Sample-rate tick from the divisor; the sender keeps its rate near nominal.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            baud_cnt <= 12'h000;
        end else begin
            baud_cnt <= tick ? baud_divisor : baud_cnt - 12'h001;
        end
    end
    assign tick = (baud_cnt == 12'h000);

    // Shifter: two stop bits always follow a 5 to 8 bit frame with its type bit.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shreg <= '1;
            left <= 4'h0;
            samp <= 4'h0;
            line <= 1'b1;
            busy <= 1'b0;
        end else if (send && !busy) begin
            shreg <= frame;
            left <= frame_len(nb, par_en, 1'b1) + ((char_size_sel != CSZ_NINE) ? 4'h1 : 4'h0);
            samp <= 4'h1;
            line <= 1'b0;
            busy <= 1'b1;
        end else if (busy && tick) begin
            samp <= samp + 4'h1;
            if (samp == last_sample(double_speed_sel)) begin
                samp <= 4'h1;
                shreg <= {1'b1, shreg[FRAME_MAX-1:1]};
                line <= shreg[1];
                left <= left - 4'h1;
                if (left == 4'h1) begin
                    busy <= 1'b0;
                    line <= 1'b1;
                end
            end
        end
    end

endmodule

// ---- verilog/uartmp_pkg.sv ----
/*
 * Shared constants for the multi-drop serial link: register map of the
 * device end, field positions, oversampling figures and frame helpers.
 * Assumes both ends and the bench import it whole.
 */
package uartmp_pkg;

    ////////////////////////////////////////////////////////////////////
    // Register offsets, one aligned 32-bit word each.
    localparam logic [11:0] ADDR_DATA = 12'h000;
    localparam logic [11:0] ADDR_CSA = 12'h004;
    localparam logic [11:0] ADDR_CSB = 12'h008;
    localparam logic [11:0] ADDR_BAUD = 12'h00C;

    // Fields of ctrl_status_a.
    localparam int CSA_AFM = 0;
    localparam int CSA_DSS = 1;
    localparam int CSA_PERR = 2;
    localparam int CSA_OVR = 3;
    localparam int CSA_FERR = 4;
    localparam int CSA_TXE = 5;
    localparam int CSA_TXC = 6;
    localparam int CSA_RXC = 7;

    // Fields of ctrl_status_b.
    localparam int CSB_RXEN = 0;
    localparam int CSB_TXEN = 1;
    localparam int CSB_CSZ = 2;
    localparam int CSB_TWO_STOP = 5;
    localparam int CSB_PAR_EN = 6;
    localparam int CSB_PAR_ODD = 7;
    localparam int CSB_TXB8 = 8;
    localparam int CSB_RXB8 = 9;

    // Reset values.
    localparam logic [9:0] CSB_RESET = 10'h00C;
    localparam logic [11:0] BAUD_RESET = 12'h000;

    ////////////////////////////////////////////////////////////////////
    // Oversampling: samples per bit and the three voting samples.
    localparam logic [3:0] SAMPLES_NORMAL = 4'h0;
    localparam logic [3:0] SAMPLES_DOUBLE = 4'h8;
    localparam logic [3:0] VOTE_FIRST_NORMAL = 4'h8;
    localparam logic [3:0] VOTE_FIRST_DOUBLE = 4'h4;
    localparam logic [3:0] VOTE_MID_NORMAL = 4'h9;
    localparam logic [3:0] VOTE_MID_DOUBLE = 4'h5;
    localparam logic [3:0] VOTE_LAST_NORMAL = 4'hA;
    localparam logic [3:0] VOTE_LAST_DOUBLE = 4'h6;
    localparam logic [2:0] CSZ_NINE = 3'h7;
    localparam int FRAME_MAX = 13;

    // Last sample number of a bit; 16 wraps to 0 in four bits.
    function automatic logic [3:0] last_sample(input logic dss);
        return dss ? SAMPLES_DOUBLE : SAMPLES_NORMAL;
    endfunction

    // Number of data bits for a character size code, 5 to 9.
    function automatic logic [3:0] data_bits(input logic [2:0] csz);
        return (csz == CSZ_NINE) ? 4'h9 : {2'b01, csz[1:0]} + 4'h1;
    endfunction

    // Serial frame, first bit in bit 0: start, data, parity, stop bits.
    function automatic logic [FRAME_MAX-1:0] build_frame(input logic [8:0] d, input logic [3:0] nb,
                                                       input logic pe, input logic odd);
        logic [FRAME_MAX-1:0] f;
        logic p;
        f = '1;
        f[0] = 1'b0;
        p = odd;
        for (int i = 0; i < 9; i++) begin
            if (i < int'(nb)) begin
                f[i + 1] = d[i];
                p = p ^ d[i];
            end
        end
        if (pe) begin
            f[nb + 4'h1] = p;
        end
        return f;
    endfunction

    // Whole frame length in bits.
    function automatic logic [3:0] frame_len(input logic [3:0] nb, input logic pe, input logic two);
        return nb + {3'b000, pe} + {3'b000, two} + 4'h2;
    endfunction

endpackage
